/* verif/flash_status_protection_props.sv */
// Port checker for the flash status and protection block
`timescale 1ns/10ps
module flash_status_protection_props
#(
    parameter BLOCK_LOCKS = 158
)
(
    // System
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // Link and events
    input wire logic i_sel_n,
    input wire logic i_power_cycle,
    // Observed outputs
    input wire logic [23:0] o_status,
    input wire logic o_commit,
    input wire logic o_rejected,
    input wire logic o_pause_enable,
    input wire logic o_quad_enable,
    input wire logic [6:0] o_drive_pct
);
logic [9:0] busy_cnt_q;
always @(posedge i_clk_sys)
    busy_cnt_q <= (i_srst || !o_status[0]) ? 10'h000 : busy_cnt_q + 10'h001;
default clocking @(posedge i_clk_sys); endclocking
default disable iff (i_srst);
//////////////////////////////
a_pause_quad: assert property (o_pause_enable != o_quad_enable)
    else $error("pause and quad enable agree");
a_quad_follow: assert property
    ($stable(o_status[9])[*3] |-> o_quad_enable == o_status[9])
    else $error("quad enable differs from status");
a_drive_map: assert property
    ($stable(o_status[22:21])[*3] |-> o_drive_pct == (o_status[22:21] == 2'h0 ? 7'h64 :
    o_status[22:21] == 2'h1 ? 7'h4b : o_status[22:21] == 2'h2 ? 7'h32 : 7'h19))
    else $error("drive percent wrong");
a_reserved_low: assert property ((o_status & 24'h9b0400) == 24'h000000)
    else $error("reserved bit set");
a_lock_sticky: assert property
    (!$past(i_srst) |-> (o_status[13:11] & $past(o_status[13:11])) == $past(o_status[13:11]))
    else $error("lock bit cleared");
a_susp_clear: assert property ($rose(i_power_cycle) |-> ##[1:6] !o_status[15])
    else $error("suspend survives power cycle");
a_commit_pulse: assert property ((o_commit || o_rejected) |=> !(o_commit || o_rejected))
    else $error("commit or reject longer than one cycle");
a_commit_idle: assert property (o_commit |-> i_sel_n)
    else $error("commit inside a frame");
a_busy_len: assert property
    (!$past(i_srst) && $fell(o_status[0]) |-> busy_cnt_q >= 10'h0ff && busy_cnt_q <= 10'h101)
    else $error("busy length wrong");
a_busy_wel: assert property ($rose(o_status[0]) |-> ##[0:2] !o_status[1])
    else $error("write enable kept during busy");
endmodule
bind flash_status_protection flash_status_protection_props #(.BLOCK_LOCKS(BLOCK_LOCKS)) u_props
(
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_sel_n(i_sel_n), .i_power_cycle(i_power_cycle),
    .o_status(o_status), .o_commit(o_commit), .o_rejected(o_rejected),
    .o_pause_enable(o_pause_enable), .o_quad_enable(o_quad_enable), .o_drive_pct(o_drive_pct)
);

/* verif/spi_host_model.sv */
// Serial host model that frames instructions for the flash status block
`timescale 1ns/10ps
module spi_host_model
(
    // Clock the host steps on
    input wire logic i_clk,
    // Serial data back from the device
    input wire logic i_sdo,
    // Serial link
    output logic o_sel_n,
    output logic o_sclk,
    output logic o_sdi
);
// Last eight bits seen on the device output at clock rises
logic [7:0] rx = 8'h00;
initial
begin
    o_sel_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
end
//////////////////////////////
// Half a link period is four system clocks, giving a 320 ns serial clock
task automatic half();
    repeat (4) @(posedge i_clk);
endtask
// Sends the top n bits of a 40-bit word; the clock stands low between frames
task automatic frame(input logic [39:0] bits, input int n);
    o_sel_n <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
        o_sdi <= bits[39-i];
        half();
        // Taken as the clock rises; the device moved it half a period earlier
        rx = {rx[6:0], i_sdo};
        o_sclk <= 1'b1;
        half();
        o_sclk <= 1'b0;
    end
    half();
    o_sel_n <= 1'b1;
    // Released data line flips so a stale level is never mistaken for data
    o_sdi <= ~o_sdi;
    half();
    half();
endtask
endmodule

/* verif/tb.sv */
// Self-checking bench for the flash status and protection block
`timescale 1ns/10ps
`include "flash_status_protection_regs.vh"
module tb;
logic i_clk_sys = 1'b0;
logic i_srst = 1'b1;
logic i_power_cycle = 1'b0;
wire sel_n;
wire sclk;
wire sdi;
wire sdo;
wire [23:0] o_status;
wire [23:0] o_commit_addr;
wire [7:0] o_commit_op;
wire [6:0] o_drive_pct;
wire o_commit;
wire o_rejected;
wire o_pause_enable;
wire o_quad_enable;
int fail_count = 0;
int compares = 0;
int cycles = 0;
int n_commit = 0;
int n_rej = 0;
logic [48:0] tbl [0:10];
always #20 i_clk_sys = ~i_clk_sys;
flash_status_protection #(.BLOCK_LOCKS(158)) u_flash_status_protection
(
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_sel_n(sel_n), .i_sclk(sclk),
    .i_serial_in_pin(sdi), .i_power_cycle(i_power_cycle), .o_status(o_status),
    .o_serial_out(sdo), .o_commit(o_commit), .o_commit_op(o_commit_op),
    .o_commit_addr(o_commit_addr), .o_rejected(o_rejected),
    .o_pause_enable(o_pause_enable), .o_quad_enable(o_quad_enable), .o_drive_pct(o_drive_pct)
);
spi_host_model host (.i_clk(i_clk_sys), .i_sdo(sdo), .o_sel_n(sel_n), .o_sclk(sclk), .o_sdi(sdi));
//////////////////////////////
task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp)
    begin
        fail_count++;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
endtask
task automatic final_report();
    if (fail_count == 0 && compares > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
// Busy may only rise a few clocks after the frame, so settle before polling
task automatic wait_idle();
    int k;
    k = 0;
    repeat (12) @(posedge i_clk_sys);
    while (o_status[0] !== 1'b0 && k < 2000)
    begin
        @(posedge i_clk_sys);
        k++;
    end
    chk({23'h0, o_status[0]}, 24'h0);
endtask
task automatic wren();
    host.frame({`OP_WREN, 32'h0}, 8);
endtask
task automatic wr_sr(input logic [7:0] op, input logic [7:0] d);
    wren();
    host.frame({op, d, 24'h0}, 16);
    wait_idle();
endtask
task automatic erase(input logic [7:0] op, input logic [23:0] a, input logic rej);
    int c0;
    int r0;
    c0 = n_commit;
    r0 = n_rej;
    wren();
    host.frame({op, a, 8'h0}, 32);
    wait_idle();
    chk(24'(n_rej - r0), {23'h0, rej});
    chk(24'(n_commit - c0), {23'h0, !rej});
    if (!rej)
        chk(o_commit_addr, a);
    if (!rej)
        chk({16'h0, o_commit_op}, {16'h0, op});
endtask
//////////////////////////////
always @(posedge i_clk_sys)
begin
    cycles <= cycles + 1;
    if (o_commit === 1'b1)
        n_commit <= n_commit + 1;
    if (o_rejected === 1'b1)
        n_rej <= n_rej + 1;
    if (cycles == 60000)
    begin
        fail_count++;
        final_report();
    end
end
initial
begin
    tbl[0] = {8'h20, 8'h04, 8'h00, 24'hfc0000, 1'b1};
    tbl[1] = {8'h20, 8'h04, 8'h00, 24'hfb0000, 1'b0};
    tbl[2] = {8'h20, 8'h24, 8'h00, 24'h000000, 1'b1};
    tbl[3] = {8'h20, 8'h24, 8'h00, 24'h040000, 1'b0};
    tbl[4] = {8'h20, 8'h44, 8'h00, 24'hfff000, 1'b1};
    tbl[5] = {8'h20, 8'h44, 8'h00, 24'hffe000, 1'b0};
    tbl[6] = {8'h20, 8'h00, 8'h00, 24'h000000, 1'b0};
    tbl[7] = {8'h20, 8'h1c, 8'h00, 24'h800000, 1'b1};
    tbl[8] = {8'h20, 8'h04, 8'h40, 24'hfb0000, 1'b1};
    tbl[9] = {8'h20, 8'h04, 8'h40, 24'hfc0000, 1'b0};
    tbl[10] = {8'h52, 8'h44, 8'h00, 24'hff8000, 1'b1};
    repeat (4) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    chk(o_status, 24'h600000);
    chk({17'h0, o_drive_pct}, 24'h000019);
    chk({22'h0, o_pause_enable, o_quad_enable}, 24'h000002);
    // A write cut short of a byte boundary
    wren();
    host.frame({`OP_WRSR1, 8'h1c, 24'h0}, 12);
    wait_idle();
    chk({21'h0, o_status[4:2]}, 24'h0);
    // Write enable sent while busy must be dropped
    wren();
    host.frame({`OP_WRSR1, 8'h00, 24'h0}, 16);
    chk({23'h0, o_status[0]}, 24'h1);
    wren();
    wait_idle();
    chk({22'h0, o_status[1:0]}, 24'h0);
    wr_sr(`OP_WRSR2, 8'h02);
    chk({21'h0, o_status[9], o_pause_enable, o_quad_enable}, 24'h5);
    for (int d = 0; d < 4; d++)
    begin
        wr_sr(`OP_WRSR3, 8'(d << 5));
        chk({17'h0, o_drive_pct}, d == 0 ? 24'h64 : d == 1 ? 24'h4b : d == 2 ? 24'h32 : 24'h19);
        chk(o_status & 24'h9b0400, 24'h0);
    end
    wr_sr(`OP_WRSR2, 8'h08);
    wr_sr(`OP_WRSR2, 8'h00);
    chk({21'h0, o_status[13:11]}, 24'h1);
    host.frame({`OP_RDSR2, 32'h0}, 16);
    chk({16'h0, host.rx}, 24'h000008);
    host.frame({`OP_RDSR3, 32'h0}, 16);
    chk({16'h0, host.rx}, 24'h000060);
    erase(`OP_SECERASE, 24'h001000, 1'b1);
    erase(`OP_SECERASE, 24'h002000, 1'b0);
    host.frame({`OP_SUSP, 32'h0}, 8);
    chk({23'h0, o_status[15]}, 24'h1);
    host.frame({`OP_RESM, 32'h0}, 8);
    chk({23'h0, o_status[15]}, 24'h0);
    host.frame({`OP_SUSP, 32'h0}, 8);
    i_power_cycle <= 1'b1;
    @(posedge i_clk_sys);
    i_power_cycle <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
    chk({23'h0, o_status[15]}, 24'h0);
    wren();
    chk({23'h0, o_status[1]}, 24'h1);
    host.frame({`OP_WRDI, 32'h0}, 8);
    chk({23'h0, o_status[1]}, 24'h0);
    for (int i = 0; i < 11; i++)
    begin
        wr_sr(`OP_WRSR1, tbl[i][40:33]);
        wr_sr(`OP_WRSR2, tbl[i][32:25]);
        erase(tbl[i][48:41], tbl[i][24:1], tbl[i][0]);
    end
    // Same erase that passed with ranges now meets the all-locked block scheme
    wr_sr(`OP_WRSR1, 8'h00);
    wr_sr(`OP_WRSR3, 8'h64);
    erase(`OP_SE4K, 24'h000000, 1'b1);
    final_report();
end
endmodule

/* verilog/flash_status_protection.v */
// Status, configuration and write protection logic of a serial flash
`timescale 1ns/10ps
`include "flash_status_protection_regs.vh"

module flash_status_protection
#(
    parameter BLOCK_LOCKS = 158
)
(
    // System
    input wire i_clk_sys,
    input wire i_srst,
    // Serial link from the host
    input wire i_sel_n,
    input wire i_sclk,
    input wire i_serial_in_pin,
    // Power cycle event, one pulse
    input wire i_power_cycle,
    // Status read back
    output reg [23:0] o_status,
    output reg o_serial_out,
    // Array commit strobes
    output reg o_commit,
    output reg [7:0] o_commit_op,
    output reg [23:0] o_commit_addr,
    output reg o_rejected,
    // Pin mode and drive
    output reg o_pause_enable,
    output reg o_quad_enable,
    output reg [6:0] o_drive_pct
);

    ////////////////////////////////////////////////////////////////////
    // Synchronisers and edges
    reg [2:0] cs_s_q;
    reg [2:0] ck_s_q;
    reg [1:0] di_s_q;
    wire cs_fall = cs_s_q[2] & ~cs_s_q[1];
    wire cs_rise = ~cs_s_q[2] & cs_s_q[1];
    wire ck_rise = ~ck_s_q[2] & ck_s_q[1] & ~cs_s_q[1];
    wire ck_fall = ck_s_q[2] & ~ck_s_q[1] & ~cs_s_q[1];

    always @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            cs_s_q <= 3'h7;
            ck_s_q <= 3'h0;
            di_s_q <= 2'h0;
        end
        else
        begin
            cs_s_q <= {cs_s_q[1:0], i_sel_n};
            ck_s_q <= {ck_s_q[1:0], i_sclk};
            di_s_q <= {di_s_q[0], i_serial_in_pin};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status bits
    reg busy_q;
    reg wel_q;
    reg [2:0] bp_q;
    reg tb_q;
    reg sec_q;
    reg qe_q;
    reg [2:0] lb_q;
    reg cmp_q;
    reg sus_q;
    reg wps_q;
    reg [1:0] drv_q;
    reg [BLOCK_LOCKS-1:0] lock_q;
    reg [15:0] busy_cnt_q;

    // Reserved positions read as zero
    wire [23:0] status_w = {1'b0, drv_q, 2'h0, wps_q, 2'h0,
        sus_q, cmp_q, lb_q, 1'b0, qe_q, 1'b0,
        1'b0, sec_q, tb_q, bp_q, wel_q, busy_q};

    ////////////////////////////////////////////////////////////////////
    // Shifter
    reg [7:0] op_q;
    reg [23:0] addr_q;
    reg [7:0] data_q;
    reg [7:0] shift_q;
    reg [2:0] bit_q;
    reg [3:0] byte_q;
    reg [23:0] rd_q;
    reg in_frame_q;

    wire [7:0] shift_n = {shift_q[6:0], di_s_q[1]};

    // Map address to a lock bit: 32 sectors in the end blocks, 126 blocks between
    function [7:0] lock_index;
        input [23:0] a;
        begin
            if (a[23:16] == 8'h00)
                lock_index = {4'h0, a[15:12]};
            else if (a[23:16] == 8'hff)
                lock_index = 8'h8e + {4'h0, a[15:12]};
            else
                lock_index = 8'h0f + a[23:16];
        end
    endfunction

    function is_write_op;
        input [7:0] op;
        begin
            is_write_op = (op == `OP_WREN) || (op == `OP_WRDI) || (op == `OP_WRSR1) ||
                (op == `OP_WRSR2) || (op == `OP_WRSR3) || (op == `OP_PP) ||
                (op == `OP_SE4K) || (op == `OP_BE32K) || (op == `OP_BE64K) ||
                (op == `OP_CE1) || (op == `OP_CE2) || (op == `OP_SECPROG) ||
                (op == `OP_SECERASE) || (op == `OP_LOCK1) || (op == `OP_UNLOCK1) ||
                (op == `OP_GLOCK) || (op == `OP_GUNLOCK);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Span of the addressed unit
    reg [23:0] span_lo;
    reg [23:0] span_hi;
    always @*
    begin
        case (op_q)
            `OP_SE4K: span_lo = {addr_q[23:12], 12'h000};
            `OP_BE32K: span_lo = {addr_q[23:15], 15'h0000};
            `OP_BE64K: span_lo = {addr_q[23:16], 16'h0000};
            `OP_PP: span_lo = {addr_q[23:8], 8'h00};
            default: span_lo = 24'h000000;
        endcase
        case (op_q)
            `OP_SE4K: span_hi = {addr_q[23:12], 12'hfff};
            `OP_BE32K: span_hi = {addr_q[23:15], 15'h7fff};
            `OP_BE64K: span_hi = {addr_q[23:16], 16'hffff};
            `OP_PP: span_hi = {addr_q[23:8], 8'hff};
            default: span_hi = 24'hffffff;
        endcase
    end

    wire range_hit;
    range_protect_check u_range
    (
        .i_bp(bp_q),
        .i_tb(tb_q),
        .i_sec(sec_q),
        .i_cmp(cmp_q),
        .i_lo(span_lo),
        .i_hi(span_hi),
        .o_hit(range_hit)
    );

    // Block lock check: chip erase needs all clear, else lo and hi units
    wire chip_op = (op_q == `OP_CE1) || (op_q == `OP_CE2);
    wire lock_hit = chip_op ? (|lock_q) :
        (lock_q[lock_index(span_lo)] | lock_q[lock_index(span_hi)]);
    wire prot_hit = wps_q ? lock_hit : range_hit;
    wire sec_hit = lb_q[addr_q[13:12] - 2'h1] && (addr_q[13:12] != 2'h0);

    ////////////////////////////////////////////////////////////////////
    // Frame and command execution
    wire end_ok = in_frame_q && cs_rise && (bit_q == 3'h0) && (byte_q != 4'h0);

    always @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            busy_q <= 1'b0;
            wel_q <= 1'b0;
            bp_q <= 3'h0;
            tb_q <= 1'b0;
            sec_q <= 1'b0;
            qe_q <= 1'b0;
            lb_q <= 3'h0;
            cmp_q <= 1'b0;
            sus_q <= 1'b0;
            wps_q <= 1'b0;
            drv_q <= `RST_DRV;
            lock_q <= {BLOCK_LOCKS{`RST_LOCKS}};
            busy_cnt_q <= 16'h0000;
            op_q <= 8'h00;
            addr_q <= 24'h000000;
            data_q <= 8'h00;
            shift_q <= 8'h00;
            bit_q <= 3'h0;
            byte_q <= 4'h0;
            rd_q <= 24'h000000;
            in_frame_q <= 1'b0;
            o_commit <= 1'b0;
            o_commit_op <= 8'h00;
            o_commit_addr <= 24'h000000;
            o_rejected <= 1'b0;
            o_serial_out <= 1'b0;
        end
        else
        begin
            o_commit <= 1'b0;
            o_rejected <= 1'b0;
            if (busy_q)
            begin
                busy_cnt_q <= busy_cnt_q - 16'h0001;
                if (busy_cnt_q == 16'h0001)
                    busy_q <= 1'b0;
            end
            if (i_power_cycle)
                sus_q <= 1'b0;
            if (cs_fall)
            begin
                in_frame_q <= 1'b1;
                bit_q <= 3'h0;
                byte_q <= 4'h0;
            end
            else if (cs_rise)
                in_frame_q <= 1'b0;
            if (in_frame_q && ck_rise)
            begin
                shift_q <= shift_n;
                bit_q <= bit_q + 3'h1;
                if (bit_q == 3'h7)
                begin
                    if (byte_q != 4'hf)
                        byte_q <= byte_q + 4'h1;
                    if (byte_q == 4'h0)
                    begin
                        op_q <= shift_n;
                        rd_q <= (shift_n == `OP_RDSR2) ? {status_w[15:8], 16'h0} :
                            (shift_n == `OP_RDSR3) ? {status_w[23:16], 16'h0} :
                            {status_w[7:0], 16'h0};
                    end
                    else if (byte_q < 4'h4)
                        addr_q <= {addr_q[15:0], shift_n};
                    else if (byte_q == 4'h4)
                        data_q <= shift_n;
                    if (byte_q == 4'h1)
                        data_q <= shift_n;
                end
            end
            if (in_frame_q && ck_fall)
            begin
                o_serial_out <= rd_q[23];
                rd_q <= {rd_q[22:0], rd_q[23]};
            end
            // Commands act at frame end; busy blocks all but status read
            if (end_ok && is_write_op(op_q) && !busy_q)
            begin
                case (op_q)
                    `OP_WREN: wel_q <= 1'b1;
                    `OP_WRDI: wel_q <= 1'b0;
                    `OP_WRSR1, `OP_WRSR2, `OP_WRSR3:
                    begin
                        if (wel_q)
                        begin
                            wel_q <= 1'b0;
                            busy_q <= 1'b1;
                            busy_cnt_q <= `BUSY_CYCLES;
                            if (op_q == `OP_WRSR1)
                            begin
                                bp_q <= data_q[4:2];
                                tb_q <= data_q[5];
                                sec_q <= data_q[6];
                            end
                            else if (op_q == `OP_WRSR2)
                            begin
                                qe_q <= data_q[1];
                                lb_q <= lb_q | data_q[5:3];
                                cmp_q <= data_q[6];
                            end
                            else
                            begin
                                wps_q <= data_q[2];
                                drv_q <= data_q[6:5];
                            end
                        end
                    end
                    `OP_LOCK1, `OP_UNLOCK1:
                        if (wel_q && byte_q >= 4'h4)
                        begin
                            lock_q[lock_index(addr_q)] <= (op_q == `OP_LOCK1);
                            wel_q <= 1'b0;
                        end
                    `OP_GLOCK, `OP_GUNLOCK:
                        if (wel_q)
                        begin
                            lock_q <= {BLOCK_LOCKS{op_q == `OP_GLOCK}};
                            wel_q <= 1'b0;
                        end
                    default:
                    begin
                        if (wel_q)
                        begin
                            wel_q <= 1'b0;
                            if (((op_q == `OP_SECPROG || op_q == `OP_SECERASE) && sec_hit)
                                || (op_q != `OP_SECPROG && op_q != `OP_SECERASE && prot_hit))
                                o_rejected <= 1'b1;
                            else
                            begin
                                busy_q <= 1'b1;
                                busy_cnt_q <= `BUSY_CYCLES;
                                o_commit <= 1'b1;
                                o_commit_op <= op_q;
                                o_commit_addr <= addr_q;
                            end
                        end
                    end
                endcase
            end
            else if (in_frame_q && cs_rise && byte_q == 4'h1 && bit_q == 3'h0)
            begin
                if (op_q == `OP_SUSP && !busy_q)
                    sus_q <= 1'b1;
                else if (op_q == `OP_RESM && !busy_q && !i_power_cycle)
                    sus_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registered outputs
    always @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            o_status <= 24'h000000;
            o_pause_enable <= 1'b1;
            o_quad_enable <= 1'b0;
            o_drive_pct <= 7'h19;
        end
        else
        begin
            o_status <= status_w;
            o_pause_enable <= ~qe_q;
            o_quad_enable <= qe_q;
            case (drv_q)
                2'h0: o_drive_pct <= 7'h64;
                2'h1: o_drive_pct <= 7'h4b;
                2'h2: o_drive_pct <= 7'h32;
                default: o_drive_pct <= 7'h19;
            endcase
        end
    end

endmodule

/* verilog/flash_status_protection_regs.vh */
// Constants for the flash status and protection block
//
// Behaviour
// - Suspend flag S15 sets after 75h
// - Resume 7Ah or power cycle clears suspend; a 75h frame ending in the power-cycle clock still sets it
// - Three OTP lock bits S13..S11, default 0
// - Lock bits never clear; area read-only
// - Quad enable S9 selects quad or pause
// - Scheme select picks range or block locks
// - Block locks all set at reset
// - Drive field decodes 100/75/50/25, default 11
// - Reserved bits ignore writes, read zero
// - Top fractions 1/64 to 1/2
// - Bottom fractions from address zero
// - Sector mode protects 4K to 32K
// - Code 000 none, 111 whole array
// - Complement inverts protected region
// - Erase/program touching protection is ignored; with block locks chip erase checks every unit, others only the span's first and last units
// - Falling select starts; first byte opcode
// - Input sampled MSB first, rising clock
// - Rising select ends; reads end anywhere
// - Writes must end on byte boundary
// - While busy only read-status accepted
// - Busy bit S0 during write cycles
// - Write enable latch S1 set/clear
// - Complement bit at S14
`ifndef FLASH_STATUS_PROTECTION_REGS_VH
`define FLASH_STATUS_PROTECTION_REGS_VH

// Opcodes
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_WRSR1 8'h01
`define OP_WRSR2 8'h31
`define OP_WRSR3 8'h11
`define OP_RDSR1 8'h05
`define OP_RDSR2 8'h35
`define OP_RDSR3 8'h15
`define OP_PP 8'h02
`define OP_SE4K 8'h20
`define OP_BE32K 8'h52
`define OP_BE64K 8'hd8
`define OP_CE1 8'hc7
`define OP_CE2 8'h60
`define OP_SUSP 8'h75
`define OP_RESM 8'h7a
`define OP_LOCK1 8'h36
`define OP_UNLOCK1 8'h39
`define OP_GLOCK 8'h7e
`define OP_GUNLOCK 8'h98
`define OP_SECPROG 8'h42
`define OP_SECERASE 8'h44

// Bit positions of the 24-bit status word
`define ST_BUSY 0
`define ST_WEL 1
`define ST_BP_LO 2
`define ST_TB 5
`define ST_SEC 6
`define ST_QE 9
`define ST_LB_LO 11
`define ST_CMP 14
`define ST_SUS 15
`define ST_WPS 18
`define ST_DRV_LO 21

// Reset values
`define RST_DRV 2'h3
`define RST_LOCKS 1'h1

// Write cycle length in system clocks
`define BUSY_CYCLES 16'h0100

`endif

/* verilog/range_protect_check.v */
// Range protection decode for one address span
`timescale 1ns/10ps
`include "flash_status_protection_regs.vh"

module range_protect_check
(
    // Protection fields
    input wire [2:0] i_bp,
    input wire i_tb,
    input wire i_sec,
    input wire i_cmp,
    // Span to test, inclusive
    input wire [23:0] i_lo,
    input wire [23:0] i_hi,
    // Result
    output reg o_hit
);

    reg [23:0] size;
    reg [23:0] base;
    reg [23:0] last;
    reg none;
    reg all;

    always @*
    begin
        size = 24'h000000;
        none = (i_bp == 3'h0);
        all = (i_bp == 3'h7);
        if (i_sec)
            size = i_bp[2] ? 24'h008000 : (24'h001000 << (i_bp[1:0] - 2'h1));
        else
            size = 24'h040000 << (i_bp - 3'h1);
        base = i_tb ? 24'h000000 : (24'h000000 - size);
        last = base + size - 24'h000001;
        if (none)
            o_hit = 1'b0;
        else if (all)
            o_hit = 1'b1;
        else
            o_hit = (i_lo <= last) && (i_hi >= base);
        // Complement: span is hit if any part lies outside the normal region
        if (i_cmp)
            o_hit = none ? 1'b1 : all ? 1'b0 : !((i_lo >= base) && (i_hi <= last));
    end

endmodule
